// ### adc_timing_control.sv
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_timing_control_consts.svh"

module adc_timing_control #(
  parameter int CAL_MIN = `CAL_MIN_BC,
  parameter int CAL_MAX = `CAL_MAX_BC
) (
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [15:0]        rdata_o,
  input  wire logic signed [11:0] ain_i,
  input  wire logic               ref_noisy_i,
  output logic      [9:0]         result_o,
  output logic                    done_o,
  output logic                    busy_o,
  output logic                    cal_busy_o,
  output logic                    cpu_clk_half_o,
  output logic      [1:0]         mclk_mode_o,
  output logic                    irq_o
);

  // ****************************************
  // Timing and clamp helpers
  // ****************************************
  function automatic logic [4:0] bc_div(input logic [1:0] sel);
    case (sel)
      2'h0:    bc_div = `BC_DIV_00;
      2'h1:    bc_div = `BC_DIV_01;
      2'h2:    bc_div = `BC_DIV_10;
      default: bc_div = `BC_DIV_11;
    endcase
  endfunction : bc_div

  function automatic logic [6:0] samp_bc(input logic [1:0] sel);
    case (sel)
      2'h0:    samp_bc = `SAMP_BC_00;
      2'h1:    samp_bc = `SAMP_BC_01;
      2'h2:    samp_bc = `SAMP_BC_10;
      default: samp_bc = `SAMP_BC_11;
    endcase
  endfunction : samp_bc

  function automatic logic [6:0] conv_bc(input logic res8, input logic pcal);
    if (res8)
      conv_bc = pcal ? `CONV8_PCAL_BC : `CONV8_BC;
    else
      conv_bc = pcal ? `CONV10_PCAL_BC : `CONV10_BC;
  endfunction : conv_bc

  function automatic logic [9:0] clamp(input logic signed [11:0] v);
    if (v < 12'sh000)
      clamp = `CODE_LOW;
    else if (v > 12'sh3ff)
      clamp = `CODE_HIGH;
    else
      clamp = v[9:0];
  endfunction : clamp

  adc_timing_control_pkg::ctl_state_s s_reg;
  adc_timing_control_pkg::ctl_state_s s_next;

  logic       sys_tick;
  logic       bc_tick;
  logic [4:0] div;
  logic       start;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    // The system clock runs at the CPU clock rate: every edge or every second one
    sys_tick    = s_reg.halve ? s_reg.sys_div : 1'b1;
    s_next.sys_div = s_reg.halve ? ~s_reg.sys_div : 1'b0;
    div         = bc_div(s_reg.ctrl[`CTRL_BCSEL_HI:`CTRL_BCSEL_LO]);
    bc_tick     = sys_tick && ({1'b0, s_reg.bc_cnt} == div - 5'h01);
    if (sys_tick)
      s_next.bc_cnt = bc_tick ? 4'h0 : s_reg.bc_cnt + 4'h1;
    start = wr_i && (addr_i == `ADDR_CTRL) && wdata_i[`CTRL_START_BIT];

    // W1C first so that a hardware set in the same cycle survives
    if (wr_i && addr_i == `ADDR_STATUS)
      s_next.status = s_reg.status & ~wdata_i[1:0];
    if (wr_i && addr_i == `ADDR_MASK)
      s_next.mask = wdata_i[1:0];
    if (wr_i && addr_i == `ADDR_CTRL)
      s_next.ctrl = wdata_i & `CTRL_WR_MASK;
    if (wr_i && addr_i == `ADDR_SYSCONF)
      s_next.halve = wdata_i[0];
    if (wr_i && addr_i == `ADDR_MCLK)
      s_next.mclk = wdata_i[1:0];

    case (s_reg.st)
      adc_timing_control_pkg::ST_IDLE:
      begin
        if (start)
        begin
          // Align the divider so the sample and conversion phases span whole basic periods
          s_next.st      = adc_timing_control_pkg::ST_SAMPLE;
          s_next.phase   = 7'h00;
          s_next.bc_cnt  = 4'h0;
          s_next.sys_div = 1'b0;
        end
        else if (s_reg.cal_busy && bc_tick)
        begin
          // Calibration pauses while converting, so conversions lengthen it
          s_next.cal_cnt = s_reg.cal_cnt + 14'h0001;
          if (ref_noisy_i && s_reg.cal_len < 14'(CAL_MAX))
            s_next.cal_len = s_reg.cal_len + 14'h0001;
          if (s_reg.cal_cnt + 14'h0001 >= s_reg.cal_len)
          begin
            s_next.cal_busy = 1'b0;
            s_next.status[`ST_CAL_BIT] = 1'b1;
          end
        end
      end
      adc_timing_control_pkg::ST_SAMPLE:
      begin
        if (bc_tick)
        begin
          if (s_reg.phase == samp_bc(s_reg.ctrl[`CTRL_STSEL_HI:`CTRL_STSEL_LO]) - 7'h01)
          begin
            s_next.st    = adc_timing_control_pkg::ST_CONV;
            s_next.phase = 7'h00;
            s_next.samp  = clamp(ain_i);
          end
          else
            s_next.phase = s_reg.phase + 7'h01;
        end
      end
      adc_timing_control_pkg::ST_CONV:
      begin
        if (bc_tick)
        begin
          if (s_reg.phase == conv_bc(s_reg.ctrl[`CTRL_RES8_BIT],
                                     s_reg.ctrl[`CTRL_POSTCAL_BIT]) - 7'h01)
          begin
            s_next.st    = adc_timing_control_pkg::ST_LOAD;
            s_next.phase = 7'h00;
          end
          else
            s_next.phase = s_reg.phase + 7'h01;
        end
      end
      adc_timing_control_pkg::ST_LOAD:
      begin
        if (sys_tick)
        begin
          if (s_reg.phase == `LOAD_SYS - 7'h01)
          begin
            s_next.st     = adc_timing_control_pkg::ST_IDLE;
            s_next.phase  = 7'h00;
            // 8-bit results keep the top bits, right-aligned
            s_next.result = s_reg.ctrl[`CTRL_RES8_BIT] ?
                            {2'b00, s_reg.samp[9:2]} : s_reg.samp;
            s_next.done   = 1'b1;
            s_next.status[`ST_DONE_BIT] = 1'b1;
          end
          else
            s_next.phase = s_reg.phase + 7'h01;
        end
      end
      default:
        s_next.st = adc_timing_control_pkg::ST_IDLE;
    endcase

    // Busy leaves a flop so the pin never glitches on a state decode
    s_next.busy  = (s_next.st != adc_timing_control_pkg::ST_IDLE);
    s_next.irq   = |(s_next.status & s_next.mask);
    s_next.rdata = 16'h0000;
    if (rd_i)
    begin
      case (addr_i)
        `ADDR_CTRL:    s_next.rdata = {s_reg.ctrl[15:4], s_reg.cal_busy, s_reg.ctrl[2:1],
                                       s_reg.st != adc_timing_control_pkg::ST_IDLE};
        `ADDR_RESULT:  s_next.rdata = {6'h00, s_reg.result};
        `ADDR_STATUS:  s_next.rdata = {14'h0000, s_reg.status};
        `ADDR_MASK:    s_next.rdata = {14'h0000, s_reg.mask};
        `ADDR_SYSCONF: s_next.rdata = {15'h0000, s_reg.halve};
        `ADDR_MCLK:    s_next.rdata = {14'h0000, s_reg.mclk};
        default:       s_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_reg          <= '0;
      s_reg.st       <= adc_timing_control_pkg::ST_IDLE;
      s_reg.ctrl     <= `CTRL_RESET;
      s_reg.cal_busy <= 1'b1;
      s_reg.cal_len  <= 14'(CAL_MIN);
    end
    else
      s_reg <= s_next;
  end

  assign rdata_o        = s_reg.rdata;
  assign result_o       = s_reg.result;
  assign done_o         = s_reg.done;
  assign busy_o         = s_reg.busy;
  assign cal_busy_o     = s_reg.cal_busy;
  assign cpu_clk_half_o = s_reg.halve;
  assign mclk_mode_o    = s_reg.mclk;
  assign irq_o          = s_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  logic [11:0] st_cyc_reg;
  logic [11:0] h;
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_cyc_reg <= 12'h000;
    else
      st_cyc_reg <= (s_next.st != s_reg.st) ? 12'h000 : st_cyc_reg + 12'h001;
  end
  assign h = s_reg.halve ? 12'h002 : 12'h001;

  sample_len_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.st == adc_timing_control_pkg::ST_SAMPLE && s_next.st == adc_timing_control_pkg::ST_CONV)
    |-> (st_cyc_reg + 12'h001 == 12'(samp_bc(s_reg.ctrl[13:12])) * 12'(div) * h))
    else $error("sample phase length wrong");
  conv_len_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.st == adc_timing_control_pkg::ST_CONV && s_next.st == adc_timing_control_pkg::ST_LOAD)
    |-> (st_cyc_reg + 12'h001 == 12'(conv_bc(s_reg.ctrl[1], s_reg.ctrl[2])) * 12'(div) * h))
    else $error("conversion phase length wrong");
  load_len_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.st == adc_timing_control_pkg::ST_LOAD && s_next.st == adc_timing_control_pkg::ST_IDLE)
    |-> (st_cyc_reg + 12'h001 == 12'h006 * h))
    else $error("load phase length wrong");
  bc_div_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.ctrl[15:14] == 2'h2 && !s_reg.halve && s_reg.st == adc_timing_control_pkg::ST_SAMPLE
     && s_next.st == adc_timing_control_pkg::ST_SAMPLE && bc_tick) |-> ##1 !bc_tick[*8])
    else $error("basic clock too fast");
  half_tick_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.halve && s_next.halve && sys_tick) |=> !sys_tick)
    else $error("halved clock ticks on adjacent edges");
  clamp_low_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.st == adc_timing_control_pkg::ST_SAMPLE && s_next.st == adc_timing_control_pkg::ST_CONV
     && ain_i < 12'sh000) |=> s_reg.samp == `CODE_LOW)
    else $error("low input not clamped");
  clamp_high_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.st == adc_timing_control_pkg::ST_SAMPLE && s_next.st == adc_timing_control_pkg::ST_CONV
     && ain_i > 12'sh3ff) |=> s_reg.samp == `CODE_HIGH)
    else $error("high input not clamped");
  cal_bounds_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(s_reg.cal_busy) |-> (s_reg.cal_cnt >= 14'(CAL_MIN) && s_reg.cal_cnt <= 14'(CAL_MAX)))
    else $error("calibration length out of bounds");
  cal_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (start && s_reg.cal_busy && s_reg.st == adc_timing_control_pkg::ST_IDLE)
    |=> busy_o && cal_busy_o)
    else $error("start during calibration ignored");
  done_load_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    done_o |-> ($past(s_reg.st) == adc_timing_control_pkg::ST_LOAD && s_reg.status[0]
                && !busy_o))
    else $error("done without result load");
  mclk_wr_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_i && addr_i == `ADDR_MCLK) |=> mclk_mode_o == $past(wdata_i[1:0]))
    else $error("master clock select not stored");
  res8_align_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (done_o && s_reg.ctrl[`CTRL_RES8_BIT]) |-> result_o[9:8] == 2'b00)
    else $error("8-bit result not right-aligned");
  cal_pause_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (s_reg.cal_busy && s_reg.st != adc_timing_control_pkg::ST_IDLE)
    |=> s_reg.cal_cnt == $past(s_reg.cal_cnt))
    else $error("calibration advanced during a conversion");

  conv10_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    done_o && !s_reg.ctrl[1]);
  conv8_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    done_o && s_reg.ctrl[1]);
  cal_conv_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    done_o && cal_busy_o);
  cal_end_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(cal_busy_o));
  half_conv_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    done_o && cpu_clk_half_o);

endmodule : adc_timing_control

// ### adc_timing_control_consts.svh
`ifndef ADC_TIMING_CONTROL_CONSTS_SVH
`define ADC_TIMING_CONTROL_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ADDR_CTRL        8'h00
`define ADDR_RESULT      8'h04
`define ADDR_STATUS      8'h08
`define ADDR_MASK        8'h0c
`define ADDR_SYSCONF     8'h10
`define ADDR_MCLK        8'h14

// ****************************************
// Control register fields
// ****************************************
`define CTRL_BCSEL_HI    15
`define CTRL_BCSEL_LO    14
`define CTRL_STSEL_HI    13
`define CTRL_STSEL_LO    12
`define CTRL_CALRUN_BIT  3
`define CTRL_POSTCAL_BIT 2
`define CTRL_RES8_BIT    1
`define CTRL_START_BIT   0
`define CTRL_WR_MASK     16'hf006
`define CTRL_RESET       16'h0004

// Status and mask bits
`define ST_DONE_BIT      0
`define ST_CAL_BIT       1

// ****************************************
// Timing, in basic-clock or system-clock periods; the reference clock period in ns
// ****************************************
`define REF_CLK_NS       20
`define CONV10_PCAL_BC   7'h34
`define CONV10_BC        7'h28
`define CONV8_PCAL_BC    7'h2c
`define CONV8_BC         7'h20
`define LOAD_SYS         7'h06
`define CAL_MIN_BC       484
`define CAL_MAX_BC       11696

// Basic clock divisors and sample lengths, by select code
`define BC_DIV_00        5'h04
`define BC_DIV_01        5'h02
`define BC_DIV_10        5'h10
`define BC_DIV_11        5'h08
`define SAMP_BC_00       7'h08
`define SAMP_BC_01       7'h10
`define SAMP_BC_10       7'h20
`define SAMP_BC_11       7'h40

// Clamp end codes
`define CODE_LOW         10'h000
`define CODE_HIGH        10'h3ff

`endif

// ### adc_timing_control_pkg.sv
package adc_timing_control_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONV,
    ST_LOAD
  } conv_state_e;

  typedef struct packed {
    conv_state_e st;
    logic [15:0] ctrl;
    logic        halve;
    logic [1:0]  mclk;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [9:0]  result;
    logic [9:0]  samp;
    logic        sys_div;
    logic [3:0]  bc_cnt;
    logic [6:0]  phase;
    logic        cal_busy;
    logic [13:0] cal_cnt;
    logic [13:0] cal_len;
    logic [15:0] rdata;
    logic        done;
    logic        busy;
    logic        irq;
  } ctl_state_s;

endpackage : adc_timing_control_pkg

// ### adc_timing_control_bench.sv
`timescale 1ns/1ps
`include "adc_timing_control_consts.svh"

module adc_timing_control_bench;
  // ****************************************
  // Design under test
  // ****************************************
  localparam int CMIN = 8;
  localparam int CMAX = 20;

  typedef struct packed {
    logic [1:0]  bc;
    logic [1:0]  st;
    logic        pc;
    logic        r8;
    logic        h;
    logic [11:0] ain;
    logic [9:0]  res;
  } row_s;

  logic               ref_clk_i;
  logic               resetn_i;
  logic [7:0]         addr_i;
  logic [15:0]        wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [15:0]        rdata_o;
  logic signed [11:0] ain_i;
  logic               ref_noisy_i;
  logic [9:0]         result_o;
  logic               done_o;
  logic               busy_o;
  logic               cal_busy_o;
  logic               cpu_clk_half_o;
  logic [1:0]         mclk_mode_o;
  logic               irq_o;
  int                 n_errors;
  int                 cmp_count;
  int                 cyc_cnt;
  int                 n;
  int                 t0;
  // Clamp rows sit on both ends, in both result widths
  // Divide-by-two rows also halve, so the basic clock stays in range
  row_s rows [6] = '{
    '{2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 12'h258, 10'h258},
    '{2'h1, 2'h1, 1'b0, 1'b0, 1'b1, 12'hffb, 10'h000},
    '{2'h2, 2'h2, 1'b1, 1'b1, 1'b0, 12'h7d0, 10'h0ff},
    '{2'h3, 2'h3, 1'b0, 1'b1, 1'b1, 12'h258, 10'h096},
    '{2'h1, 2'h0, 1'b1, 1'b0, 1'b1, 12'h5dc, 10'h3ff},
    '{2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 12'hfff, 10'h000}};

  adc_timing_control #(.CAL_MIN(CMIN), .CAL_MAX(CMAX)) u_adc_timing_control (
    .ref_clk_i      (ref_clk_i),
    .resetn_i       (resetn_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .ain_i          (ain_i),
    .ref_noisy_i    (ref_noisy_i),
    .result_o       (result_o),
    .done_o         (done_o),
    .busy_o         (busy_o),
    .cal_busy_o     (cal_busy_o),
    .cpu_clk_half_o (cpu_clk_half_o),
    .mclk_mode_o    (mclk_mode_o),
    .irq_o          (irq_o)
  );

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rd

  // Counts edges after a start until done, or until the limit
  task automatic run(output int k, input int lim);
    k = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end while (done_o !== 1'b1 && k < lim);
  endtask : run

  function automatic int ncyc(input row_s r);
    int s;
    int c;
    int d;
    int h;
    s = 8 << r.st;
    c = r.r8 ? (r.pc ? 44 : 32) : (r.pc ? 52 : 40);
    d = (r.bc == 2'h0) ? 4 : (r.bc == 2'h1) ? 2 : (r.bc == 2'h2) ? 16 : 8;
    h = r.h ? 2 : 1;
    return (s + c) * d * h + 6 * h;
  endfunction : ncyc

  task automatic do_reset();
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1;
    t0 = cyc_cnt;
  endtask : do_reset

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // Longest path is well under 20k cycles
  always @(posedge ref_clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  initial
  begin
    resetn_i = 1'b0; addr_i = 8'h00; wdata_i = 16'h0000; wr_i = 1'b0; rd_i = 1'b0;
    ain_i = 12'sh000; ref_noisy_i = 1'b0; n_errors = 0; cmp_count = 0; cyc_cnt = 0;
    do_reset();
    rd(`ADDR_CTRL, 16'h000c, "ctrl");
    rd(8'h20, 16'h0000, "unmapped");
    while (cal_busy_o === 1'b1 && cyc_cnt - t0 < 2000)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    n = cyc_cnt - t0;
    chk("cal_len", 16'h1, 16'(n >= 4 * CMIN && n <= 4 * CMIN + 4));
    rd(`ADDR_STATUS, 16'h0002, "cal_status");
    wr(`ADDR_MCLK, 16'h0003);
    rd(`ADDR_MCLK, 16'h0003, "mclk");
    chk("mclk_pin", 16'h3, {14'h0, mclk_mode_o});
    wr(`ADDR_RESULT, 16'h03ff);
    wr(8'h20, 16'hffff);
    rd(`ADDR_RESULT, 16'h0000, "ro_result");
    foreach (rows[i])
    begin
      @(posedge ref_clk_i);
      ain_i <= rows[i].ain;
      wr(`ADDR_SYSCONF, {15'h0, rows[i].h});
      wr(`ADDR_STATUS, 16'h0003);
      wr(`ADDR_MASK, 16'h0001);
      chk("half", {15'h0, rows[i].h}, {15'h0, cpu_clk_half_o});
      wr(`ADDR_CTRL, {rows[i].bc, rows[i].st, 9'h0, rows[i].pc, rows[i].r8, 1'b1});
      run(n, 5000);
      chk("cycles", 16'(ncyc(rows[i])), 16'(n));
      chk("result", {6'h0, rows[i].res}, {6'h0, result_o});
      @(posedge ref_clk_i);
      #1;
      chk("irq", 16'h1, {15'h0, irq_o});
      rd(`ADDR_RESULT, {6'h0, rows[i].res}, "result_reg");
    end
    // Clear, then mask: a fresh done must stay silent
    wr(`ADDR_STATUS, 16'h0001);
    @(posedge ref_clk_i);
    #1;
    chk("irq_clr", 16'h0, {15'h0, irq_o});
    wr(`ADDR_MASK, 16'h0000);
    wr(`ADDR_SYSCONF, 16'h0000);
    wr(`ADDR_CTRL, 16'h0005);
    repeat (20) @(posedge ref_clk_i);
    chk("busy", 16'h1, {15'h0, busy_o});
    wr(`ADDR_CTRL, 16'h0005);
    run(n, 5000);
    chk("busy_start", 16'(ncyc(rows[0])), 16'(n + 22));
    run(n, 300);
    chk("no_second", 16'd300, 16'(n));
    chk("irq_masked", 16'h0, {15'h0, irq_o});
    rd(`ADDR_STATUS, 16'h0001, "sticky");
    // Noisy reference and a conversion inside calibration
    @(posedge ref_clk_i);
    ref_noisy_i <= 1'b1;
    do_reset();
    wr(`ADDR_CTRL, 16'h0005);
    run(n, 5000);
    chk("cal_conv", 16'(ncyc(rows[0])), 16'(n));
    chk("cal_busy", 16'h1, {15'h0, cal_busy_o});
    while (cal_busy_o === 1'b1 && cyc_cnt - t0 < 3000)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    n = cyc_cnt - t0;
    chk("cal_ext", 16'h1, 16'(n >= 250 + 4 * (CMIN + 1) && n <= 260 + 4 * CMAX));
    give_verdict();
  end
endmodule : adc_timing_control_bench
